// ### design/adcct_host.sv
// Host controller driving the converter registers on software request
// ------------------------------------------------------------------
// Behaviour
// - Analog pins: input, no pull-up, no dier
// - Exactly one channel per conversion
// - Setup order: reference, clock, pins, channel
// - Wait 200 conversion clocks before converting
// - Internal levels: at least 1 ms too
// - Keep fast oscillator on for internal reference
// - Settle counted in divided clocks
// - Write go bit, poll until it reads 1
// - Read high result byte first
// - Settle again after any change
// - Zero written to control disables converter
// - Prefer a divider near 2 us
// ------------------------------------------------------------------
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module adcct_host
  import adcct_pkg::*;
#(
  parameter int SETTLE_MS_CYC = SETTLE_MIN_CYC // Shorten in simulation
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [7:0]  DEV_ADDR,
  output logic      [7:0]  DEV_WDATA,
  output logic             DEV_WR,
  output logic             DEV_RD,
  input  wire logic [7:0]  DEV_RDATA,
  output logic             FAST_OSC_ON
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adcct_state_t state;       // Sequencer state
  adcct_state_t next_state;  // Next sequencer state
  logic [16:0] cfg;          // Software setup
  logic [16:0] applied;      // Setup last sent to the device
  logic [2:0]  step;         // Setup write index
  logic        enabled;      // Converter believed on
  logic        done;         // Result ready
  logic [11:0] result;       // Last result
  logic [7:0]  hi_byte;      // High result byte held for pairing
  logic        hi_seen;      // High byte read in this conversion
  logic        settle_go;    // Restart settle timer
  logic        settled;      // Settle timer over
  logic        wr_ok;        // APB write access
  logic        map_ok;       // Address is mapped
  logic        go_cmd;       // Start requested
  logic        off_cmd;      // Power-off requested
  logic        need_ms;      // Internal levels in use
  logic [16:0] step_word;    // {valid, addr, data} of setup step
  logic [7:0]  next_addr;    // Next device address
  logic [7:0]  next_wdata;   // Next device write data
  logic        next_wr;      // Next device write strobe
  logic        next_rd;      // Next device read strobe

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when a reference or channel uses the internal level circuit
  function automatic logic uses_int(input logic [16:0] c);
    uses_int = (c[CFG_CH_LSB +: 4] == CH_INT)
            || (c[CFG_REF_LSB +: 3] != REF_VDD
                && c[CFG_REF_LSB +: 3] != REF_PIN);
  endfunction : uses_int

  function automatic logic [7:0] chan_mask(input logic [3:0] ch);
    case (ch)
      4'h8:    chan_mask = 8'h01;
      4'h9:    chan_mask = 8'h08;
      4'hA:    chan_mask = 8'h10;
      default: chan_mask = 8'(8'h01 << ch[2:0]);
    endcase
  endfunction : chan_mask

  function automatic logic [16:0] cfg_step(input logic [2:0]  s,
                                           input logic [16:0] c);
    logic [3:0] ch;
    logic       pb;
    logic       pin;
    ch  = c[CFG_CH_LSB +: 4];
    pb  = (ch < 4'h8);
    pin = (ch != CH_INT);
    case (s)
      3'h0: cfg_step = {1'b1, D_ADCRGC, c[CFG_REF_LSB +: 3],
                        c[CFG_LVL_LSB +: 2], c[CFG_QTR], 2'b00};
      // Divider as software picked it, ideally 2 us
      3'h1: cfg_step = {1'b1, D_ADCM, 4'h0, c[CFG_DIV_LSB +: 3], 1'b0};
      3'h2: cfg_step = {pin, pb ? D_PBC : D_PAC, 8'h00};
      3'h3: cfg_step = {pin, pb ? D_PBPH : D_PAPH, 8'h00};
      3'h4: cfg_step = {pin, pb ? D_PBDIER : D_PADIER, ~chan_mask(ch)};
      3'h5: cfg_step = {1'b1, D_ADCC, 2'b00, ch, 2'b00};
      3'h6: cfg_step = {1'b1, D_ADCC, 2'b10, ch, 2'b00};
      default: cfg_step = 17'h00000;
    endcase
  endfunction : cfg_step

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states keep the master simple
  assign PREADY  = 1'b1;
  assign map_ok  = (PADDR == A_CTRL) || (PADDR == A_CFG)
                || (PADDR == A_STAT) || (PADDR == A_RES);
  assign PSLVERR = PSEL && PENABLE && !map_ok;
  assign wr_ok   = PSEL && PENABLE && PWRITE && map_ok;
  assign go_cmd  = wr_ok && PADDR == A_CTRL && PWDATA[CTRL_GO];
  assign off_cmd = wr_ok && PADDR == A_CTRL && PWDATA[CTRL_OFF];

  // Setup register, frozen while busy so the sequence sees one value
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg <= CFG_RESET;
    end else if (wr_ok && PADDR == A_CFG && state == S_IDLE) begin
      cfg <= PWDATA[16:0];
    end
  end

  // Read data captured in the setup phase, stable in the access phase
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        A_CFG:   PRDATA <= {15'h0000, cfg};
        A_STAT:  PRDATA <= {28'h0000000, enabled, settled, done,
                            state != S_IDLE};
        A_RES:   PRDATA <= {20'h00000, result};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next setup step: the first of the new setup, later ones in turn
  assign step_word = (state == S_IDLE) ? cfg_step(3'h0, cfg)
                   : cfg_step(step + 3'h1, applied);
  assign need_ms   = uses_int(applied);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (off_cmd) begin
          next_state = S_OFF;
        end else if (go_cmd) begin
          next_state = (enabled && cfg == applied) ? S_START : S_CFG;
        end
      end
      S_CFG: begin
        if (step == STEP_LAST) begin
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (settled && !settle_go) begin
          next_state = S_START;
        end
      end
      S_START:  next_state = S_POLL;
      S_POLL:   next_state = S_POLL_W;
      S_POLL_W: next_state = DEV_RDATA[ADCC_GO] ? S_RD_HI : S_POLL;
      S_RD_HI:  next_state = S_HI_W;
      S_HI_W:   next_state = S_RD_LO;
      S_RD_LO:  next_state = S_LO_W;
      S_LO_W:   next_state = S_IDLE;
      S_OFF:    next_state = S_IDLE;
      default:  next_state = S_IDLE;
    endcase
  end

  // Device strobes and data for the next cycle
  always_comb begin
    next_addr  = DEV_ADDR;
    next_wdata = DEV_WDATA;
    next_wr    = 1'b0;
    next_rd    = 1'b0;
    case (next_state)
      S_CFG: begin
        // Step taken from the setup about to be applied
        next_addr  = step_word[15:8];
        next_wdata = step_word[7:0];
        next_wr    = step_word[16];
      end
      S_START: begin
        next_addr  = D_ADCC;
        next_wdata = {2'b11, applied[CFG_CH_LSB +: 4], 2'b00};
        next_wr    = 1'b1;
      end
      S_POLL: begin
        next_addr = D_ADCC;
        next_rd   = 1'b1;
      end
      S_RD_HI: begin
        next_addr = D_ADCRH;
        next_rd   = 1'b1;
      end
      S_RD_LO: begin
        next_addr = D_ADCRL;
        next_rd   = 1'b1;
      end
      S_OFF: begin
        next_addr  = D_ADCC;
        next_wdata = 8'h00;
        next_wr    = 1'b1;
      end
      default: begin
        next_wr = 1'b0;
      end
    endcase
  end

  // State and device bus registers
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state     <= S_IDLE;
      DEV_ADDR  <= 8'h00;
      DEV_WDATA <= 8'h00;
      DEV_WR    <= 1'b0;
      DEV_RD    <= 1'b0;
    end else begin
      state     <= next_state;
      DEV_ADDR  <= next_addr;
      DEV_WDATA <= next_wdata;
      DEV_WR    <= next_wr;
      DEV_RD    <= next_rd;
    end
  end

  // Setup step index and applied setup
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      step    <= 3'h0;
      applied <= CFG_RESET;
    end else if (state == S_IDLE && next_state == S_CFG) begin
      step    <= 3'h0;
      applied <= cfg;
    end else if (state == S_CFG) begin
      step <= step + 3'h1;
    end
  end

  // Converter on/off and settle trigger
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      enabled   <= 1'b0;
      settle_go <= 1'b0;
    end else begin
      settle_go <= (state == S_CFG && step == STEP_LAST);
      if (state == S_CFG && step == STEP_LAST) begin
        enabled <= 1'b1;
      end else if (state == S_OFF) begin
        enabled <= 1'b0;
      end
    end
  end

  // Result capture; done clears on a start request in idle, even when off is written with it
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hi_byte <= 8'h00;
      hi_seen <= 1'b0;
      result  <= 12'h000;
      done    <= 1'b0;
    end else begin
      if (state == S_IDLE && go_cmd) begin
        done    <= 1'b0;
        hi_seen <= 1'b0;
      end
      if (state == S_HI_W) begin
        hi_byte <= DEV_RDATA;
        hi_seen <= 1'b1;
      end
      if (state == S_LO_W) begin
        result <= {hi_byte, DEV_RDATA[7:4]};
        done   <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FAST_OSC_ON <= 1'b0;
    end else begin
      FAST_OSC_ON <= (enabled || state == S_CFG) && need_ms;
    end
  end

  adcct_settle #(
    .MS_CYC (SETTLE_MS_CYC)
  ) u_settle (
    .clk     (CORE_CLK),
    .rst     (SYS_RST),
    .go      (settle_go),
    .div     (applied[CFG_DIV_LSB +: 3]),
    .need_ms (need_ms),
    .settled (settled)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  chk_off_zero: assert property (state == S_OFF |-> DEV_WR
    && DEV_ADDR == D_ADCC && DEV_WDATA == 8'h00)
    else $error("power-off did not write zero to control");
  chk_start_go: assert property (state == S_START |-> DEV_WR
    && DEV_ADDR == D_ADCC && DEV_WDATA[ADCC_GO] && DEV_WDATA[ADCC_EN])
    else $error("start write lacks go or enable");
  chk_hi_first: assert property (DEV_RD && DEV_ADDR == D_ADCRL
    |-> hi_seen)
    else $error("low result byte read before high");
  chk_settle_start: assert property ($rose(state == S_START)
    && $past(state) == S_SETTLE |-> settled)
    else $error("conversion started before settling");
  chk_one_chan: assert property (DEV_WR && DEV_ADDR == D_ADCC
    |-> DEV_WDATA[5:2] <= CH_LAST)
    else $error("channel field out of range");
  chk_dier_off: assert property (DEV_WR && DEV_ADDR == D_PBDIER
    |-> (DEV_WDATA & chan_mask(applied[CFG_CH_LSB +: 4])) == 8'h00)
    else $error("analog pin left with digital input on");
  chk_cfg_order: assert property ($rose(state == S_CFG)
    |-> DEV_WR && DEV_ADDR == D_ADCRGC ##6 DEV_WR && DEV_ADDR == D_ADCC
    && DEV_WDATA[ADCC_EN])
    else $error("setup writes out of order");
  chk_osc_on: assert property (enabled && need_ms
    |=> FAST_OSC_ON)
    else $error("fast oscillator off with internal reference");
  chk_resettle: assert property (state == S_IDLE && go_cmd
    && !off_cmd && cfg != applied |=> state == S_CFG ##8 !settled)
    else $error("setup change skipped the settle wait");

  cov_result: cover property ($rose(done));
  cov_poll_again: cover property (state == S_POLL_W
    && !DEV_RDATA[ADCC_GO]);
  cov_power_off: cover property (state == S_OFF);
  cov_fast_repeat: cover property (state == S_IDLE && go_cmd
    && enabled && cfg == applied);
endmodule : adcct_host

// ### design/adcct_pkg.sv
// Shared constants and types of the converter host controller
package adcct_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;    // CORE_CLK period
  localparam int SETTLE_MIN_US  = 1000;  // Least wait with internal levels
  localparam int SETTLE_MIN_CYC =
    (SETTLE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CONVERSION_CLOCK = 8'hC8; // 200 conversion clocks

  // ----------------------------------------------------------------
  // Own register map (APB byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00; // W: bit0 start, bit1 off
  localparam logic [7:0] A_CFG  = 8'h04; // RW: conversion setup
  localparam logic [7:0] A_STAT = 8'h08; // R: state bits
  localparam logic [7:0] A_RES  = 8'h0C; // R: 12-bit result
  localparam int CTRL_GO  = 0;
  localparam int CTRL_OFF = 1;
  localparam int CFG_REF_LSB = 0;  // [2:0] high reference
  localparam int CFG_DIV_LSB = 4;  // [6:4] divider setting
  localparam int CFG_CH_LSB  = 8;  // [11:8] channel
  localparam int CFG_LVL_LSB = 12; // [13:12] internal level
  localparam int CFG_QTR     = 16; // internal source is quarter supply
  localparam logic [16:0] CFG_RESET = 17'h00000;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_SETL = 2;
  localparam int ST_EN   = 3;

  // ----------------------------------------------------------------
  // Device register addresses and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] D_ADCC   = 8'h2B;
  localparam logic [7:0] D_ADCM   = 8'h2C;
  localparam logic [7:0] D_ADCRGC = 8'h2D;
  localparam logic [7:0] D_ADCRH  = 8'h2E;
  localparam logic [7:0] D_ADCRL  = 8'h2F;
  localparam logic [7:0] D_PAC    = 8'h11;
  localparam logic [7:0] D_PAPH   = 8'h12;
  localparam logic [7:0] D_PADIER = 8'h0D;
  localparam logic [7:0] D_PBC    = 8'h15;
  localparam logic [7:0] D_PBPH   = 8'h16;
  localparam logic [7:0] D_PBDIER = 8'h0E;
  localparam int ADCC_EN = 7;
  localparam int ADCC_GO = 6;   // Write 1 starts, reads 1 when ready
  localparam logic [3:0] CH_INT  = 4'hB; // Internal source channel
  localparam logic [3:0] CH_LAST = 4'hB;
  localparam logic [2:0] REF_VDD = 3'h0;
  localparam logic [2:0] REF_PIN = 3'h4; // external_reference_pin
  localparam logic [2:0] STEP_LAST = 3'h6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CFG, S_SETTLE, S_START, S_POLL, S_POLL_W,
    S_RD_HI, S_HI_W, S_RD_LO, S_LO_W, S_OFF
  } adcct_state_t;
endpackage : adcct_pkg

// ### design/adcct_settle.sv
// Settling delay timer counted in conversion clock periods
`timescale 1ns/1ps
module adcct_settle
  import adcct_pkg::*;
#(
  parameter int MS_CYC = SETTLE_MIN_CYC  // System cycles of the 1 ms floor
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,       // Restart the wait
  input  wire logic [2:0] div,      // Divider setting 0..7
  input  wire logic       need_ms,  // Internal levels in use
  output logic            settled   // Level: wait is over
);
  logic [6:0]  pre;      // Prescaler inside one conversion clock
  logic [7:0]  ticks;    // Conversion clocks counted
  logic [15:0] ms_left;  // System cycles left of the floor
  logic        running;  // Wait in progress
  logic        tick;     // End of one conversion clock period

  // ----------------------------------------------------------------
  // Conversion clock period
  // ----------------------------------------------------------------
  function automatic logic [6:0] period_m1(input logic [2:0] d);
    period_m1 = 7'((8'h01 << d) - 8'h01);
  endfunction : period_m1

  assign tick = running && (pre == period_m1(div));

  // Prescaler restarts with each wait so the first period is whole
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= 7'h00;
    end else if (go || tick) begin
      pre <= 7'h00;
    end else if (running) begin
      pre <= pre + 7'h01;
    end
  end

  // Tick and floor counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ticks   <= 8'h00;
      ms_left <= 16'h0000;
    end else if (go) begin
      ticks   <= 8'h00;
      ms_left <= need_ms ? 16'(MS_CYC) : 16'h0000;
    end else begin
      if (tick && ticks != SETTLE_CONVERSION_CLOCK) begin
        ticks <= ticks + 8'h01;
      end
      if (running && ms_left != 16'h0000) begin
        ms_left <= ms_left - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      settled <= 1'b0;
    end else if (go) begin
      running <= 1'b1;
      settled <= 1'b0;
    end else if (running && ticks == SETTLE_CONVERSION_CLOCK
                 && ms_left == 16'h0000) begin
      running <= 1'b0;
      settled <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Full 200 clocks
  chk_settle_ticks: assert property (@(posedge clk) disable iff (rst)
    $rose(settled) |-> ticks == SETTLE_CONVERSION_CLOCK)
    else $error("settled before 200 conversion clocks");
  chk_settle_floor: assert property (@(posedge clk) disable iff (rst)
    $rose(settled) |-> ms_left == 16'h0000)
    else $error("settled before the millisecond floor");
endmodule : adcct_settle

// ### tb/adcct_dev_model.sv
// Behavioural model of the converter device behind the host
`timescale 1ns/1ps
module adcct_dev_model
  import adcct_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  dev_addr,
  input  wire logic [7:0]  dev_wdata,
  input  wire logic        dev_wr,
  input  wire logic        dev_rd,
  output logic      [7:0]  dev_rdata,
  input  wire logic [11:0] res_val,   // Next conversion result
  input  wire logic [7:0]  dly        // Conversion length, at least 1
);
  logic [7:0] regs [256];  // Register file by device address
  logic [7:0] cnt;         // Cycles left of a conversion
  int         since_en;    // Cycles since the enable write
  int         settle_seen; // Wait seen before the last start
  logic       hi_rd;       // High byte read since the result
  logic       bad_order;   // Low byte read before the high byte
  logic       irq_fwd;     // Converter request seen by the processor
  localparam logic [7:0] IRQ_EN  = 8'h04; // Interrupt enable register
  localparam logic [7:0] IRQ_REQ = 8'h05; // Interrupt request register

  assign irq_fwd = regs[IRQ_EN][3] && regs[IRQ_REQ][3];
  // ----------------------------------------------------------
  // Registers and conversion
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= 8'h00;
      end
      dev_rdata   <= 8'h00;
      cnt         <= 8'h00;
      since_en    <= 0;
      settle_seen <= 0;
      hi_rd       <= 1'b0;
      bad_order   <= 1'b0;
    end else begin
      since_en  <= since_en + 1;
      // Idle read bus toggles, so a late sample never looks right
      dev_rdata <= ~dev_rdata;
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (dev_wr) begin
        regs[dev_addr] <= dev_wdata;
      end
      if (dev_wr && dev_addr == D_ADCC && dev_wdata[7:6] == 2'b10) begin
        since_en <= 0;
      end
      // start loads the conversion count, clears ready
      if (dev_wr && dev_addr == D_ADCC && dev_wdata[7:6] == 2'b11) begin
        regs[D_ADCC] <= dev_wdata & 8'hBF;
        cnt          <= dly;
        settle_seen  <= since_en;
      end
      if (cnt == 8'h01) begin
        regs[D_ADCC][ADCC_GO] <= 1'b1;
        regs[D_ADCRH]         <= res_val[11:4];
        regs[D_ADCRL]         <= {res_val[3:0], 4'h0};
        // request flag set at the end, cleared only by software
        regs[IRQ_REQ][3]      <= 1'b1;
        hi_rd                 <= 1'b0;
      end
      if (dev_rd) begin
        dev_rdata <= regs[dev_addr];
        hi_rd     <= (hi_rd && cnt != 8'h01) || dev_addr == D_ADCRH;
        bad_order <= bad_order | (dev_addr == D_ADCRL && !hi_rd);
      end
    end
  end
endmodule : adcct_dev_model

// ### tb/adcct_host_tb.sv
// Self-checking bench of the converter host controller
`timescale 1ns/1ps
module adcct_host_tb
  import adcct_pkg::*;
;
  localparam int MS = 300;  // Shortened floor of the internal wait
  logic        CORE_CLK = 1'b0;
  logic        SYS_RST  = 1'b1;
  logic        PSEL     = 1'b0;
  logic        PENABLE  = 1'b0;
  logic        PWRITE   = 1'b0;
  logic [7:0]  PADDR    = 8'h00;
  logic [31:0] PWDATA   = 32'h00000000;
  logic [11:0] res_val  = 12'h000;
  logic [7:0]  dly      = 8'h01;
  logic [31:0] PRDATA, q, cfg_last;
  logic [7:0]  DEV_ADDR, DEV_WDATA, DEV_RDATA;
  logic        PREADY, PSLVERR, DEV_WR, DEV_RD, FAST_OSC_ON;
  logic [65:0] exp_q [$];  // Checked reads: {mask, expected}
  logic [65:0] ent;
  int          failures  = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  logic [2:0]  refs [4] = '{3'h0, 3'h4, 3'h2, 3'h5};
  logic [2:0]  divs [4] = '{3'h0, 3'h2, 3'h7, 3'h0};
  logic [3:0]  chs  [4] = '{4'h8, 4'h9, 4'h3, 4'hB};

  always #12.5 CORE_CLK = ~CORE_CLK;

  adcct_host #(.SETTLE_MS_CYC(MS)) adcct_host_inst (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA),
    .DEV_WR(DEV_WR), .DEV_RD(DEV_RD), .DEV_RDATA(DEV_RDATA),
    .FAST_OSC_ON(FAST_OSC_ON)
  );
  adcct_dev_model adcct_dev_model_inst (
    .clk(CORE_CLK), .rst(SYS_RST), .dev_addr(DEV_ADDR),
    .dev_wdata(DEV_WDATA), .dev_wr(DEV_WR), .dev_rd(DEV_RD),
    .dev_rdata(DEV_RDATA), .res_val(res_val), .dly(dly)
  );

  task automatic chk(input string n, input logic [32:0] e,
                     input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  function automatic logic [7:0] dreg(input logic [7:0] a);
    return adcct_dev_model_inst.regs[a];
  endfunction : dreg

  // Bus cycle: request held until the edge that samples ready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [31:0] m);
    exp_q.push_back({1'b1, m, e});
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic poll();
    do begin
      apb(1'b0, A_STAT, 32'h00000000);
    end while (q[ST_DONE] !== 1'b1);
  endtask : poll

  // One full conversion with a given setup, then device state checks
  task automatic conv(input int k);
    logic [3:0] ch;
    logic [7:0] g;
    logic       intl;
    int         need;
    ch = (k == 0) ? 4'($urandom % 11) : chs[k];
    cfg_last = {15'h0, 1'($urandom), 2'b00, 2'($urandom), ch, 1'b0,
                divs[k], 1'b0, refs[k]};
    intl = (refs[k] != 3'h0 && refs[k] != 3'h4) || ch == 4'hB;
    need = 200 << divs[k];
    if (intl && need < MS) begin
      need = MS;
    end
    res_val <= 12'($urandom);
    dly     <= 8'($urandom % 40 + 1);
    apb(1'b1, A_CFG, cfg_last);
    rd(A_CFG, {1'b0, cfg_last}, 32'hFFFFFFFF);
    apb(1'b1, A_CTRL, 32'h00000001);
    poll();
    rd(A_RES, {21'h000000, res_val}, 32'hFFFFFFFF);
    chk("settle", 33'h1,
        33'(adcct_dev_model_inst.settle_seen >= need));
    chk("osc", 33'(intl), 33'(FAST_OSC_ON));
    g = dreg(D_ADCRGC);
    chk("ref", 33'(refs[k]), 33'(g[7:5]));
    chk("level", 33'(cfg_last[13:12]), 33'(g[4:3]));
    chk("quarter", 33'(cfg_last[16]), 33'(g[2]));
    g = dreg(8'h05);
    chk("irq flag", 33'h1, 33'(g[3]));
    chk("irq fwd", 33'h0, 33'(adcct_dev_model_inst.irq_fwd));
    g = dreg(D_ADCM);
    chk("div", 33'(divs[k]), 33'(g[3:1]));
    g = dreg(D_ADCC);
    chk("chan", 33'(ch), 33'(g[5:2]));
    if (ch != 4'hB) begin
      g = ~(8'h01 << ((ch < 4'h8) ? ch : (ch == 4'h8) ? 4'h0 : ch - 4'h6));
      chk("dier", 33'(g), 33'(dreg(ch < 8 ? D_PBDIER : D_PADIER)));
      chk("dir", 33'h0, 33'(dreg(ch < 8 ? D_PBC : D_PAC)));
      chk("pullup", 33'h0, 33'(dreg(ch < 8 ? D_PBPH : D_PAPH)));
    end
    chk("order", 33'h0, 33'(adcct_dev_model_inst.bad_order));
  endtask : conv

  // Read watcher and hang limit
  always @(posedge CORE_CLK) begin
    cyc++;
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE
        && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      chk("apb read", ent[32:0], {PSLVERR, PRDATA} & ent[65:33]);
    end
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    q = $urandom(37);
    repeat (20) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    rd(A_STAT, 33'h000000000, 32'hFFFFFFFF);
    rd(8'h10, {1'b1, 32'h00000000}, 32'hFFFFFFFF);
    for (int k = 0; k < 4; k++) begin
      conv(k);
    end
    // Setup change while busy is refused
    dly <= 8'h28;
    apb(1'b1, A_CTRL, 32'h00000001);
    apb(1'b1, A_CFG, 32'h00000000);
    rd(A_STAT, 33'h000000001, 32'h00000001);
    rd(A_CFG, {1'b0, cfg_last}, 32'hFFFFFFFF);
    poll();
    // Power off, then a restart must wait again
    apb(1'b1, A_CTRL, 32'h00000002);
    repeat (4) @(posedge CORE_CLK);
    chk("off", 33'h0, 33'(dreg(D_ADCC)));
    rd(A_STAT, 33'h000000000, 32'h00000008);
    apb(1'b1, A_CTRL, 32'h00000001);
    poll();
    chk("resettle", 33'h1,
        33'(adcct_dev_model_inst.settle_seen >= MS));
    close_out();
  end
endmodule : adcct_host_tb
